// file: common/cpu_status_pkg.sv
// Purpose: constants for the status and workspace logic of the microcomputer core
// Assumes: byte addresses, word registers reached over classic Wishbone
// Notes:   bit numbers of the status word count from the msb (bit 0 = msb)
// Overview of operation
// - decode program memory and data RAM ranges
// - interrupt vectors in words 0000..000F
// - trap vectors at 0050..007F, traps 4-15
// - vector areas otherwise plain program memory
// - 11-bit pointer concatenated with register number
// - status bit 6 not implemented
// - status bit 7 is digit carry
// - two-bit interrupt mask in bits 14-15
// - four interrupt levels, decrementer is one source
// - decimal correct writes carry, digit carry, clears overflow
// - add, sub, inc, dec update digit carry
// - word ops: carry from upper byte low digit
// - byte ops: carry from low digit
// - short load mask sets mask bits from opcode low bits
// - load mask immediate copies operand bits
// - return restores mask from register 15
// - added instructions decode in 2C00..2CFF
// - short load mask leaves bits 0-13
// - add correct carry on upper fix; sub keeps carry
package cpu_status_pkg;
   localparam logic [15:0] PROG_LO      = 16'h0000;
   localparam logic [15:0] PROG_HI      = 16'h07FF;
   localparam logic [15:0] RAM_LO       = 16'h8300;
   localparam logic [15:0] RAM_HI       = 16'h837F;
   localparam logic [15:0] IVEC_LO      = 16'h0000;
   localparam logic [15:0] IVEC_HI      = 16'h000F;
   localparam logic [15:0] TVEC_LO      = 16'h0050;
   localparam logic [15:0] TVEC_HI      = 16'h007F;
   localparam logic [15:0] TVEC_BASE    = 16'h0040;
   localparam logic [15:0] ADDED_LO     = 16'h2C00;
   localparam logic [15:0] ADDED_HI     = 16'h2CFF;
   localparam logic [15:0] OP_DCA       = 16'h2C00;
   localparam logic [15:0] OP_DCS       = 16'h2C40;
   localparam logic [15:0] OP_MASK_SH   = 16'h2C80;
   localparam logic [15:0] OP_GRP_MASK  = 16'hFFC0;
   // implemented bits: 0-5, 7, 14, 15 (lsb numbering: 15..10, 8, 1, 0)
   localparam logic [15:0] ST_IMPL_MASK = 16'hFD03;
   localparam int          ST_DC_BIT    = 8;
   localparam int          ST_C_BIT     = 12;
   localparam int          ST_O_BIT     = 11;
   localparam int          ST_P_BIT     = 10;
   localparam int          ST_EQ_BIT    = 13;
   localparam int          ST_AGT_BIT   = 14;
   localparam int          ST_LGT_BIT   = 15;
   localparam logic [15:0] ST_RESET     = 16'h0000;
   localparam int          WP_BITS      = 11;
   localparam logic [15:0] LEVEL_FOUR_MASK = 16'h0003;
   // wishbone byte offsets
   localparam logic [4:0] A_STATUS   = 5'h00;
   localparam logic [4:0] A_WP       = 5'h04;
   localparam logic [4:0] A_OPCODE   = 5'h08;
   localparam logic [4:0] A_OPERAND  = 5'h0C;
   localparam logic [4:0] A_RESULT   = 5'h10;
   localparam logic [4:0] A_CTRL     = 5'h14;
   localparam logic [4:0] A_REGNUM   = 5'h18;
   localparam logic [4:0] A_ADDRINFO = 5'h1C;
   typedef enum logic [2:0] {
      OPK_NONE, OPK_DCA, OPK_DCS, OPK_MASK_SH, OPK_MASK_IMM, OPK_RETURN,
      OPK_WORD_ARITH, OPK_BYTE_ARITH
   } op_kind_t;
endpackage

// file: logic/cpu_status_core.sv
// Purpose: status word, workspace addressing and memory map of the core
// Assumes: one 20 MHz clock, classic Wishbone slave with one-wait ack
// Notes:   software posts an operation and its operands, then writes CTRL.go
module cpu_status_core
   import cpu_status_pkg::*;
(
   // clock and reset
   input  wire logic        clk_in,
   input  wire logic        rst_b_in,
   // wishbone slave
   input  wire logic        wb_cyc_in,
   input  wire logic        wb_stb_in,
   input  wire logic        wb_we_in,
   input  wire logic [4:0]  wb_adr_in,
   input  wire logic [3:0]  wb_sel_in,
   input  wire logic [31:0] wb_dat_in,
   output logic      [31:0] wb_dat_out,
   output logic             wb_ack_out,
   // memory map probe
   input  wire logic [15:0] probe_addr_in,
   output logic             prog_sel_out,
   output logic             ram_sel_out,
   output logic             ivec_area_out,
   output logic             tvec_area_out,
   // interrupt levels, decrementer is level source 3
   input  wire logic [2:0]  ext_irq_in,
   input  wire logic        decr_irq_in,
   output logic             irq_take_out,
   output logic [1:0]       irq_level_out,
   output logic [15:0]      irq_vector_out
);
   logic [15:0] status_reg, status_next;
   logic [10:0] wp_reg, wp_next;
   logic [15:0] opcode_reg, opcode_next;
   logic [15:0] operand_reg, operand_next;
   logic [15:0] result_reg, result_next;
   logic [3:0]  regnum_reg, regnum_next;
   logic [4:0]  kind_reg, kind_next;
   logic        ack_reg, ack_next;
   logic [31:0] rdat_reg, rdat_next;
   logic        bad_op_reg, bad_op_next;
   logic        wr, go;
   logic [15:0] ws_addr;
   op_kind_t    kind;

   function automatic logic in_range(input logic [15:0] a, input logic [15:0] lo,
                                     input logic [15:0] hi);
      in_range = (a >= lo) && (a <= hi);
   endfunction

   function automatic logic parity8(input logic [7:0] b);
      parity8 = ^b;
   endfunction

   assign prog_sel_out  = in_range(probe_addr_in, PROG_LO, PROG_HI);
   assign ram_sel_out   = in_range(probe_addr_in, RAM_LO, RAM_HI);
   assign ivec_area_out = in_range(probe_addr_in, IVEC_LO, IVEC_HI);
   assign tvec_area_out = in_range(probe_addr_in, TVEC_LO, TVEC_HI);

   assign ws_addr = {wp_reg, regnum_reg, 1'b0};

   // four levels, lower number wins, gated by mask
   always_comb begin
      logic [3:0] req;
      req            = {decr_irq_in, ext_irq_in};
      irq_take_out   = 1'b0;
      irq_level_out  = 2'b00;
      for (int i = 3; i >= 0; i--) begin
         if (req[i] && (2'(i) <= status_reg[1:0])) begin
            irq_take_out  = 1'b1;
            irq_level_out = 2'(i);
         end
      end
      irq_vector_out = {12'h000, irq_level_out, 2'b00};
   end

   assign wr = wb_cyc_in && wb_stb_in && wb_we_in && !ack_reg;
   assign go = wr && (wb_adr_in == A_CTRL) && wb_sel_in[0] && wb_dat_in[0];

   always_comb begin
      kind = OPK_NONE;
      if (in_range(opcode_reg, ADDED_LO, ADDED_HI)) begin
         if ((opcode_reg & OP_GRP_MASK) == OP_DCA)
            kind = OPK_DCA;
         else if ((opcode_reg & OP_GRP_MASK) == OP_DCS)
            kind = OPK_DCS;
         else if ((opcode_reg & OP_GRP_MASK) == OP_MASK_SH)
            kind = OPK_MASK_SH;
      end else begin
         // selector travels with the go write; the stored copy is only read back
         unique case (wb_dat_in[5:1])
            5'h03:   kind = OPK_MASK_IMM;
            5'h04:   kind = OPK_RETURN;
            5'h05:   kind = OPK_WORD_ARITH;
            5'h06:   kind = OPK_BYTE_ARITH;
            default: kind = OPK_NONE;
         endcase
      end
   end

   always_comb begin
      logic [3:0]  x, y;
      logic [4:0]  ys;
      logic [4:0]  xs;
      logic [7:0]  b;
      logic        c, dc, dnew;
      status_next  = status_reg;
      wp_next      = wp_reg;
      opcode_next  = opcode_reg;
      operand_next = operand_reg;
      result_next  = result_reg;
      regnum_next  = regnum_reg;
      kind_next    = kind_reg;
      bad_op_next  = bad_op_reg;
      b  = operand_reg[15:8];
      x  = b[7:4];
      y  = b[3:0];
      c  = status_reg[ST_C_BIT];
      dc = status_reg[ST_DC_BIT];
      ys = 5'd0;
      xs = 5'd0;
      dnew = 1'b0;
      if (wr) begin
         unique case (wb_adr_in)
            A_STATUS:  if (wb_sel_in[0] && wb_sel_in[1])
                          status_next = wb_dat_in[15:0] & ST_IMPL_MASK;
            A_WP:      if (wb_sel_in[1:0] == 2'b11) wp_next = wb_dat_in[15:5];
            A_OPCODE:  if (wb_sel_in[1:0] == 2'b11) opcode_next = wb_dat_in[15:0];
            A_OPERAND: if (wb_sel_in[1:0] == 2'b11) operand_next = wb_dat_in[15:0];
            A_REGNUM:  if (wb_sel_in[0]) regnum_next = wb_dat_in[3:0];
            A_CTRL:    if (wb_sel_in[0]) kind_next = wb_dat_in[5:1];
            default:   ;
         endcase
      end
      if (go) begin
         bad_op_next = 1'b0;
         unique case (kind)
            OPK_DCA: begin
               ys = {1'b0, y};
               if (dc || (y >= 4'd10)) ys = ys + 5'd6;
               xs = {1'b0, x} + {4'd0, ys[4]};
               dnew = ys[4];
               if (c || (x >= 4'd10) || ((x >= 4'd9) && (y >= 4'd10))) begin
                  xs = xs + 5'd6;
                  status_next[ST_C_BIT] = 1'b1;
               end else
                  status_next[ST_C_BIT] = 1'b0;
               result_next = {xs[3:0], ys[3:0], operand_reg[7:0]};
               status_next[ST_DC_BIT] = dnew;
               status_next[ST_O_BIT]  = 1'b0;
            end
            OPK_DCS: begin
               ys = dc ? {1'b0, y} : {1'b0, y} + 5'd10;
               xs = c ? {1'b0, x} : {1'b0, x} + 5'd10;
               result_next = {xs[3:0], ys[3:0], operand_reg[7:0]};
               status_next[ST_C_BIT]  = c;
               status_next[ST_DC_BIT] = !dc;
               status_next[ST_O_BIT]  = 1'b0;
            end
            OPK_MASK_SH: begin
               status_next[1:0] = opcode_reg[1:0];
            end
            OPK_MASK_IMM: begin
               status_next[1:0] = operand_reg[1:0];
            end
            OPK_RETURN: begin
               status_next = operand_reg & ST_IMPL_MASK;
            end
            OPK_WORD_ARITH: begin
               // digit carry from upper byte low digit
               ys = {1'b0, operand_reg[11:8]} + {1'b0, opcode_reg[11:8]};
               status_next[ST_DC_BIT] = ys[4];
            end
            OPK_BYTE_ARITH: begin
               ys = {1'b0, operand_reg[11:8]} + {1'b0, opcode_reg[11:8]};
               status_next[ST_DC_BIT] = ys[4];
            end
            default: bad_op_next = 1'b1;
         endcase
         if ((kind == OPK_DCA) || (kind == OPK_DCS)) begin
            status_next[ST_EQ_BIT]  = (result_next[15:8] == 8'h00);
            status_next[ST_LGT_BIT] = (result_next[15:8] != 8'h00);
            status_next[ST_AGT_BIT] = !result_next[15] && (result_next[15:8] != 8'h00);
            status_next[ST_P_BIT]   = parity8(result_next[15:8]);
         end
         status_next = status_next & ST_IMPL_MASK;
      end
   end

   always_comb begin
      ack_next  = wb_cyc_in && wb_stb_in && !ack_reg;
      rdat_next = 32'h0000_0000;
      unique case (wb_adr_in)
         A_STATUS:   rdat_next = {16'h0000, status_reg};
         A_WP:       rdat_next = {16'h0000, wp_reg, 5'h00};
         A_OPCODE:   rdat_next = {16'h0000, opcode_reg};
         A_OPERAND:  rdat_next = {16'h0000, operand_reg};
         A_RESULT:   rdat_next = {16'h0000, result_reg};
         A_CTRL:     rdat_next = {26'h0, bad_op_reg, kind_reg};
         A_REGNUM:   rdat_next = {12'h000, ws_addr, regnum_reg};
         A_ADDRINFO: rdat_next = {28'h0, tvec_area_out, ivec_area_out,
                                  ram_sel_out, prog_sel_out};
         default:    rdat_next = 32'h0000_0000;
      endcase
   end

   always_ff @(posedge clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         status_reg  <= ST_RESET;
         wp_reg      <= 11'h000;
         opcode_reg  <= 16'h0000;
         operand_reg <= 16'h0000;
         result_reg  <= 16'h0000;
         regnum_reg  <= 4'h0;
         kind_reg    <= 5'h00;
         bad_op_reg  <= 1'b0;
         ack_reg     <= 1'b0;
         rdat_reg    <= 32'h0000_0000;
      end else begin
         status_reg  <= status_next;
         wp_reg      <= wp_next;
         opcode_reg  <= opcode_next;
         operand_reg <= operand_next;
         result_reg  <= result_next;
         regnum_reg  <= regnum_next;
         kind_reg    <= kind_next;
         bad_op_reg  <= bad_op_next;
         ack_reg     <= ack_next;
         rdat_reg    <= rdat_next;
      end
   end

   assign wb_ack_out = ack_reg;
   assign wb_dat_out = rdat_reg;
endmodule // cpu_status_core

// file: dv/cpu_status_core_properties.sv
// Purpose: port-level checks of the status and workspace core
// Assumes: one clock domain, asynchronous active-low reset
// Notes:   bound to every instance of the core
module cpu_status_core_properties (
   // clock and reset
   input wire logic        clk_in,
   input wire logic        rst_b_in,
   // bus handshake
   input wire logic        wb_cyc_in,
   input wire logic        wb_stb_in,
   input wire logic        wb_ack_out,
   // memory map probe
   input wire logic [15:0] probe_addr_in,
   input wire logic        prog_sel_out,
   input wire logic        ram_sel_out,
   input wire logic        ivec_area_out,
   input wire logic        tvec_area_out,
   // interrupt levels
   input wire logic [2:0]  ext_irq_in,
   input wire logic        decr_irq_in,
   input wire logic        irq_take_out,
   input wire logic [1:0]  irq_level_out,
   input wire logic [15:0] irq_vector_out
);
   timeunit 1ns;
   timeprecision 1ns;
   default clocking cb @(posedge clk_in); endclocking
   default disable iff (!rst_b_in);
   sequence s_taken;
      wb_cyc_in && wb_stb_in && !wb_ack_out;
   endsequence
   sequence s_answer;
      wb_ack_out ##1 !wb_ack_out;
   endsequence
   AST_ACK_NEXT: assert property (s_taken |=> s_answer)
      else $error("ack not one cycle after request");
   AST_ACK_CAUSE: assert property ($rose(wb_ack_out) |-> $past(wb_cyc_in && wb_stb_in))
      else $error("ack without request");
   AST_PROG_SEL: assert property (prog_sel_out == (probe_addr_in <= 16'h07FF))
      else $error("program memory decode wrong");
   AST_RAM_SEL: assert property (ram_sel_out ==
      (probe_addr_in >= 16'h8300 && probe_addr_in <= 16'h837F))
      else $error("data ram decode wrong");
   AST_IVEC: assert property (ivec_area_out == (probe_addr_in <= 16'h000F))
      else $error("interrupt vector area wrong");
   AST_TVEC: assert property (tvec_area_out ==
      (probe_addr_in >= 16'h0050 && probe_addr_in <= 16'h007F))
      else $error("trap vector area wrong");
   AST_VECTOR: assert property (irq_take_out |->
      irq_vector_out == {12'h000, irq_level_out, 2'h0})
      else $error("vector not level times four");
   AST_LEVEL0: assert property (ext_irq_in[0] |-> irq_take_out && irq_level_out == 2'h0)
      else $error("level zero not taken first");
   AST_NO_REQ: assert property (ext_irq_in == 3'h0 && !decr_irq_in |-> !irq_take_out)
      else $error("interrupt taken with no request");
endmodule // cpu_status_core_properties

bind cpu_status_core cpu_status_core_properties chk (
   .clk_in(clk_in), .rst_b_in(rst_b_in), .wb_cyc_in(wb_cyc_in), .wb_stb_in(wb_stb_in),
   .wb_ack_out(wb_ack_out), .probe_addr_in(probe_addr_in), .prog_sel_out(prog_sel_out),
   .ram_sel_out(ram_sel_out), .ivec_area_out(ivec_area_out), .tvec_area_out(tvec_area_out),
   .ext_irq_in(ext_irq_in), .decr_irq_in(decr_irq_in), .irq_take_out(irq_take_out),
   .irq_level_out(irq_level_out), .irq_vector_out(irq_vector_out));

// file: dv/decrementer_model.sv
// Purpose: decrementer interrupt source beside the core
// Assumes: start value loaded by a one-cycle pulse
// Notes:   request holds until the next load
module decrementer_model (
   // clock, reset, control
   input  wire logic       clk_in,
   input  wire logic       rst_b_in,
   input  wire logic       load_in,
   input  wire logic [7:0] start_in,
   // request to the core
   output logic            irq_out
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [7:0] count_reg;
   always_ff @(posedge clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         count_reg <= 8'h00;
         irq_out   <= 1'b0;
      end else if (load_in) begin
         count_reg <= start_in;
         irq_out   <= 1'b0;
      end else if (count_reg != 8'h00) begin
         count_reg <= count_reg - 8'h01;
         irq_out   <= (count_reg == 8'h01);
      end
   end
endmodule // decrementer_model

// file: dv/cpu_status_core_tb.sv
// Purpose: register-level test of the status and workspace core
// Assumes: one-wait bus answer, status bits numbered lsb-first on the bus
// Notes:   decrementer model drives interrupt level 3
`define CHK(nm, got, exp) begin n_compared++; if ((got) !== (exp)) begin errors++; \
   $display("mismatch %s expected %h seen %h", nm, exp, got); end end
module cpu_status_core_tb;
   import cpu_status_pkg::*;
   timeunit 1ns;
   timeprecision 1ns;
   logic        clk_in = 1'b0;
   logic        rst_b_in = 1'b0;
   logic        cyc = 1'b0;
   logic        we = 1'b0;
   logic        load = 1'b0;
   logic [4:0]  adr = 5'h00;
   logic [31:0] wdat = 32'h0000_0000;
   logic [31:0] rdat, q;
   logic        ack, take, decr, psel, rsel, iv, tv;
   logic [1:0]  lvl;
   logic [15:0] vec;
   logic [15:0] probe = 16'h0000;
   logic [2:0]  ext = 3'h0;
   logic [15:0] pa [11] = '{16'h0000, 16'h000F, 16'h0010, 16'h0050, 16'h007F, 16'h0080,
                            16'h07FF, 16'h82FF, 16'h8300, 16'h837F, 16'h8380};
   logic [3:0]  map_exp;
   int          errors = 0;
   int          n_compared = 0;
   always #25 clk_in = ~clk_in;
   cpu_status_core DUT (.clk_in(clk_in), .rst_b_in(rst_b_in), .wb_cyc_in(cyc),
      .wb_stb_in(cyc), .wb_we_in(we), .wb_adr_in(adr), .wb_sel_in(4'hF), .wb_dat_in(wdat),
      .wb_dat_out(rdat), .wb_ack_out(ack), .probe_addr_in(probe), .prog_sel_out(psel),
      .ram_sel_out(rsel), .ivec_area_out(iv), .tvec_area_out(tv), .ext_irq_in(ext),
      .decr_irq_in(decr), .irq_take_out(take), .irq_level_out(lvl), .irq_vector_out(vec));
   decrementer_model dec (.clk_in(clk_in), .rst_b_in(rst_b_in), .load_in(load),
      .start_in(8'h03), .irq_out(decr));
   task close_out;
      if (errors == 0 && n_compared > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask
   task xfer(input logic w, input logic [4:0] a, input logic [15:0] d);
      int n;
      @(posedge clk_in);
      cyc  <= 1'b1;
      we   <= w;
      adr  <= a;
      wdat <= {16'h0000, d};
      n = 0;
      do begin
         @(posedge clk_in);
         n++;
      end while (ack !== 1'b1 && n < 20);
      q = rdat;
      cyc <= 1'b0;
      if (n >= 20) begin
         errors++;
         close_out();
      end
   endtask
   task rd(input logic [4:0] a, input logic [31:0] m, input logic [31:0] e, input string nm);
      xfer(1'b0, a, 16'h0000);
      `CHK(nm, q & m, e)
   endtask
   task op(input logic [15:0] opnd, input logic [15:0] opc, input logic [15:0] ctl);
      xfer(1'b1, A_OPERAND, opnd);
      xfer(1'b1, A_OPCODE, opc);
      xfer(1'b1, A_CTRL, ctl);
   endtask
   task irq(input logic [2:0] e, input logic [18:0] x);
      @(posedge clk_in);
      ext <= e;
      @(negedge clk_in);
      `CHK("irq", {take, lvl, vec}, x)
   endtask
   initial begin
      repeat (8) @(posedge clk_in);
      rst_b_in <= 1'b1;
      rd(A_STATUS, 32'hFFFF_FFFF, 32'h0, "status reset");
      xfer(1'b1, A_STATUS, 16'hFFFF);
      rd(A_STATUS, 32'hFFFF_FFFF, 32'hFD03, "status unused");
      op(16'h0000, 16'h2C82, 16'h0001);
      rd(A_STATUS, 32'hFFFF, 32'hFD02, "short mask");
      op(16'h0001, 16'h0000, 16'h0007);
      rd(A_STATUS, 32'hFFFF, 32'hFD01, "mask immediate");
      op(16'h8102, 16'h0000, 16'h0009);
      rd(A_STATUS, 32'hFFFF, 32'h8102, "return");
      @(posedge clk_in);
      load <= 1'b1;
      @(posedge clk_in);
      load <= 1'b0;
      repeat (6) @(posedge clk_in);
      irq(3'h0, {1'h0, 2'h0, 16'h0000} & 19'h40000);
      xfer(1'b1, A_STATUS, 16'h0003);
      irq(3'h0, {1'h1, 2'h3, 16'h000C});
      irq(3'h2, {1'h1, 2'h1, 16'h0004});
      xfer(1'b1, A_STATUS, 16'h0000);
      irq(3'h2, {1'h0, 2'h0, 16'h0000} & 19'h40000);
      irq(3'h1, {1'h1, 2'h0, 16'h0000});
      irq(3'h0, 19'h00000);
      xfer(1'b1, A_WP, 16'hABCD);
      rd(A_WP, 32'hFFFF, 32'hABC0, "pointer");
      xfer(1'b1, A_REGNUM, 16'h0005);
      rd(A_REGNUM, 32'h000F_FFF0, 32'h000A_BCA0, "reg address");
      op(16'h0D00, 16'h2C00, 16'h0001);
      rd(A_RESULT, 32'hFF00, 32'h1300, "add correct");
      rd(A_STATUS, 32'h1900, 32'h0100, "add flags");
      op(16'h9A00, 16'h2C00, 16'h0001);
      rd(A_STATUS, 32'h1900, 32'h1100, "add carry");
      xfer(1'b1, A_STATUS, 16'h1000);
      op(16'h0F00, 16'h2C40, 16'h0001);
      rd(A_RESULT, 32'hFF00, 32'h0900, "sub correct");
      rd(A_STATUS, 32'h1900, 32'h1100, "sub flags");
      op(16'h0800, 16'h0800, 16'h000B);
      rd(A_STATUS, 32'h0100, 32'h0100, "word digit");
      op(16'h0100, 16'h0100, 16'h000D);
      rd(A_STATUS, 32'h0100, 32'h0000, "byte digit");
      op(16'h0000, 16'h0000, 16'h0001);
      rd(A_CTRL, 32'h3F, 32'h20, "no operation");
      rd(5'h01, 32'hFFFF_FFFF, 32'h0, "unmapped");
      foreach (pa[i]) begin
         @(posedge clk_in);
         probe <= pa[i];
         @(negedge clk_in);
         map_exp = {pa[i] <= 16'h07FF, pa[i] >= 16'h8300 && pa[i] <= 16'h837F,
                    pa[i] <= 16'h000F, pa[i] >= 16'h0050 && pa[i] <= 16'h007F};
         `CHK("map", {psel, rsel, iv, tv}, map_exp)
      end
      close_out();
   end
endmodule // cpu_status_core_tb
